/* File: src/lbrs_regs.svh */
// register map, field positions and reset values of the branch record stack
`ifndef LBRS_REGS_SVH
`define LBRS_REGS_SVH

// register addresses
`define LBRS_ADDR_ENTRY0   32'h0000_0040
`define LBRS_ADDR_TOP      32'h0000_01c9
`define LBRS_ADDR_CTL      32'h0000_01d9
`define LBRS_ADDR_LER_SRC  32'h0000_01dd
`define LBRS_ADDR_LER_DST  32'h0000_01de

// debug control fields
`define LBRS_CTL_REC_BIT   0
`define LBRS_CTL_STEP_BIT  1
`define LBRS_CTL_MSG_BIT   6
`define LBRS_CTL_STORE_BIT 7
`define LBRS_CTL_IRQ_BIT   8
`define LBRS_CTL_WMASK     64'h0000_0000_0000_01c3
`define LBRS_CTL_RESET     64'h0000_0000_0000_0000

// identification result, store support flag
`define LBRS_FEATURE_STORE_BIT 21

`endif

/* File: src/lbrs_pkg.sv */
// types shared by the branch record stack
package lbrs_pkg;

  // what kind of control transfer a record describes
  typedef enum logic [1:0]
  {
    LBRS_KIND_BRANCH,
    LBRS_KIND_INTERRUPT,
    LBRS_KIND_EXCEPTION
  } lbrs_kind_type;

  // one record; destination in the upper word, source in the lower
  typedef struct packed
  {
    logic [31:0] dest;
    logic [31:0] src;
  } lbrs_rec_type;

  // event from the core's retirement logic
  typedef struct packed
  {
    lbrs_kind_type kind;
    logic          with_branch;  // branch retired just before, push it too
    lbrs_rec_type  branch_rec;   // that branch's record
    lbrs_rec_type  rec;          // record of the event itself
  } lbrs_evt_type;

endpackage : lbrs_pkg

/* File: src/lbrs_stack.sv */
// branch, interrupt and exception record stack with its register port
`include "lbrs_regs.svh"

module lbrs_stack
#(
  parameter int unsigned DEPTH = 8   // 4, 8 or 16 entries
)
(
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_N_IN,
  // record events from the core
  input  wire logic                  EVT_VALID_IN,
  input  wire lbrs_pkg::lbrs_evt_type EVT_IN,
  output logic                       EVT_READY_OUT,
  // single-step support
  input  wire logic                  TRAP_FLAG_IN,
  input  wire logic                  INSN_RETIRE_IN,
  input  wire logic                  DBG_EXC_IN,
  output logic                       STEP_TRAP_OUT,
  // bus trace messages and store requests
  output logic                       TRACE_VALID_OUT,
  output logic                       STORE_VALID_OUT,
  output lbrs_pkg::lbrs_rec_type     TRACE_REC_OUT,
  input  wire logic                  BUF_FULL_IN,
  output logic                       BUF_IRQ_OUT,
  output logic                       STORE_CIRCULAR_OUT,
  // identification feature word
  output logic [31:0]                FEATURES_OUT,
  // model-specific register access
  input  wire logic                  MSR_RD_IN,
  input  wire logic                  MSR_WR_IN,
  input  wire logic [31:0]           MSR_ADDR_IN,
  input  wire logic [63:0]           MSR_WDATA_IN,
  output logic [63:0]                MSR_RDATA_OUT,
  output logic                       MSR_ACK_OUT,
  output logic                       MSR_FAULT_OUT
);
  import lbrs_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_MAX = PW'(DEPTH - 1);

  // storage and state
  // circular record stack
  lbrs_rec_type  stack [DEPTH];    // record entries
  logic [PW-1:0] ptr;              // index of newest record
  logic [63:0]   ctl;              // debug control register
  lbrs_rec_type  last_branch;      // most recent branch record
  lbrs_rec_type  ler;              // last-exception pair
  logic          second_pending;   // second half of a paired push
  lbrs_rec_type  second_rec;       // record held for that half
  lbrs_kind_type second_kind;      // kind held for that half
  logic          full_q;           // buffer full, previous cycle

  // push of this cycle
  logic          push;
  lbrs_rec_type  push_rec;
  lbrs_kind_type push_kind;
  logic          take;
  logic          rec_en;
  logic [PW-1:0] next_ptr;

  // true when an address falls inside the entry window
  function automatic logic is_entry(input logic [31:0] a);
    return (a >= `LBRS_ADDR_ENTRY0) &&
           (a < (`LBRS_ADDR_ENTRY0 + 32'(DEPTH)));
  endfunction

  // pointer step with wrap
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    return (p == PTR_MAX) ? '0 : PW'(p + 1'b1);
  endfunction

  assign take   = EVT_VALID_IN && EVT_READY_OUT;
  assign rec_en = ctl[`LBRS_CTL_REC_BIT];
  assign next_ptr = step(ptr);

  // choose what to push; a paired event goes branch first
  always_comb
  begin
    push      = 1'b0;
    push_rec  = EVT_IN.rec;
    push_kind = EVT_IN.kind;
    if (second_pending)
    begin
      push      = 1'b1;
      push_rec  = second_rec;
      push_kind = second_kind;
    end
    else if (take)
    begin
      push = 1'b1;
      if (EVT_IN.with_branch && EVT_IN.kind != LBRS_KIND_BRANCH)
      begin
        push_rec  = EVT_IN.branch_rec;
        push_kind = LBRS_KIND_BRANCH;
      end
    end
  end

  // holds the event record while its branch goes first
  // one stall cycle per pair keeps a single write port on the stack
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      second_pending <= 1'b0;
      second_rec     <= '0;
      second_kind    <= LBRS_KIND_BRANCH;
      EVT_READY_OUT  <= 1'b1;
    end
    else if (!second_pending && take && EVT_IN.with_branch &&
             EVT_IN.kind != LBRS_KIND_BRANCH)
    begin
      second_pending <= 1'b1;
      second_rec     <= EVT_IN.rec;
      second_kind    <= EVT_IN.kind;
      EVT_READY_OUT  <= 1'b0;  // stall core for the second push
    end
    else
    begin
      second_pending <= 1'b0;
      EVT_READY_OUT  <= 1'b1;
    end
  end

  // stack pointer and entry written together
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ptr <= '0;
      for (int i = 0; i < DEPTH; i++)
        stack[i] <= '0;
    end
    else if (push && rec_en)
    begin
      ptr             <= next_ptr;
      stack[next_ptr] <= push_rec;
    end
  end

  // last branch and last-exception pair
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      last_branch <= '0;
      ler         <= '0;
    end
    else if (push && rec_en)
    begin
      if (push_kind == LBRS_KIND_BRANCH)
        last_branch <= push_rec;
      else
        ler <= last_branch;
    end
  end

  // debug control register; hardware clear beats a software set
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      ctl <= `LBRS_CTL_RESET;
    else
    begin
      if (MSR_WR_IN && MSR_ADDR_IN == `LBRS_ADDR_CTL)
        ctl <= MSR_WDATA_IN & `LBRS_CTL_WMASK;
      if (DBG_EXC_IN)
        ctl[`LBRS_CTL_REC_BIT] <= 1'b0;
    end
  end

  // single-step trap on branches or instructions
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      STEP_TRAP_OUT <= 1'b0;
    else if (ctl[`LBRS_CTL_STEP_BIT])
      STEP_TRAP_OUT <= TRAP_FLAG_IN && push &&
                       push_kind == LBRS_KIND_BRANCH;
    else
      STEP_TRAP_OUT <= TRAP_FLAG_IN && INSN_RETIRE_IN;
  end

  // trace message and store request per pushed record
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      TRACE_VALID_OUT <= 1'b0;
      STORE_VALID_OUT <= 1'b0;
      TRACE_REC_OUT   <= '0;
    end
    else
    begin
      TRACE_VALID_OUT <= push && ctl[`LBRS_CTL_MSG_BIT];
      STORE_VALID_OUT <= push && ctl[`LBRS_CTL_STORE_BIT];
      if (push)
        TRACE_REC_OUT <= push_rec;
    end
  end

  // buffer full interrupt or circular logging
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      full_q             <= 1'b0;
      BUF_IRQ_OUT        <= 1'b0;
      STORE_CIRCULAR_OUT <= 1'b0;
    end
    else
    begin
      full_q <= BUF_FULL_IN;
      // pulse on the rising full edge
      BUF_IRQ_OUT <= BUF_FULL_IN && !full_q &&
                     ctl[`LBRS_CTL_STORE_BIT] && ctl[`LBRS_CTL_IRQ_BIT];
      STORE_CIRCULAR_OUT <= ctl[`LBRS_CTL_STORE_BIT] &&
                            !ctl[`LBRS_CTL_IRQ_BIT];
    end
  end

  // identification word; only the store support flag is set
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      FEATURES_OUT <= '0;
    else
    begin
      FEATURES_OUT <= 32'h0000_0000;
      FEATURES_OUT[`LBRS_FEATURE_STORE_BIT] <= 1'b1;
    end
  end

  // register read and write answers, one cycle after the request
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      MSR_RDATA_OUT <= '0;
      MSR_ACK_OUT   <= 1'b0;
      MSR_FAULT_OUT <= 1'b0;
    end
    else
    begin
      MSR_ACK_OUT   <= MSR_RD_IN || MSR_WR_IN;
      MSR_FAULT_OUT <= 1'b0;
      MSR_RDATA_OUT <= '0;
      if (MSR_WR_IN)
        // only the control register takes writes
        MSR_FAULT_OUT <= (MSR_ADDR_IN != `LBRS_ADDR_CTL);
      else if (MSR_RD_IN)
      begin
        if (is_entry(MSR_ADDR_IN))
          MSR_RDATA_OUT <=
            stack[PW'(MSR_ADDR_IN - `LBRS_ADDR_ENTRY0)];
        else if (MSR_ADDR_IN == `LBRS_ADDR_TOP)
          MSR_RDATA_OUT <= 64'(ptr);
        else if (MSR_ADDR_IN == `LBRS_ADDR_CTL)
          MSR_RDATA_OUT <= ctl;
        else if (MSR_ADDR_IN == `LBRS_ADDR_LER_SRC)
          MSR_RDATA_OUT <= 64'(ler.src);
        else if (MSR_ADDR_IN == `LBRS_ADDR_LER_DST)
          MSR_RDATA_OUT <= 64'(ler.dest);
        else
          MSR_FAULT_OUT <= 1'b1;  // unmapped address
      end
    end
  end

  // checks on the recording behaviour
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_branch_push;
    push && push_kind == LBRS_KIND_BRANCH;
  endsequence

  sequence s_event_push(lbrs_kind_type k);
    push && push_kind == k;
  endsequence

  chk_ptr_advance: assert property (
    push && rec_en && ptr != PTR_MAX |=> ptr == $past(ptr) + 1'b1)
    else $error("pointer did not advance by one");

  chk_ptr_wrap: assert property (
    push && rec_en && ptr == PTR_MAX |=> ptr == '0)
    else $error("pointer did not wrap to zero");

  chk_entry_top: assert property (
    push && rec_en |=> stack[ptr] == $past(push_rec))
    else $error("newest entry not at pointer");

  chk_pair_order: assert property (
    take && EVT_IN.with_branch && EVT_IN.kind != LBRS_KIND_BRANCH
    |-> s_branch_push ##1 s_event_push(second_kind) ##1 EVT_READY_OUT)
    else $error("paired records out of order");

  chk_record_off: assert property (
    !rec_en |=> $stable(ptr))
    else $error("stack moved while recording off");

  chk_ro_write: assert property (
    MSR_WR_IN && MSR_ADDR_IN == `LBRS_ADDR_TOP
    |=> MSR_ACK_OUT && MSR_FAULT_OUT)
    else $error("write to pointer register not refused");

  chk_dbg_clear: assert property (
    DBG_EXC_IN |=> !ctl[`LBRS_CTL_REC_BIT])
    else $error("debug exception left recording on");

  chk_trace_msg: assert property (
    push && ctl[`LBRS_CTL_MSG_BIT]
    |=> TRACE_VALID_OUT && TRACE_REC_OUT == $past(push_rec))
    else $error("trace message missing or wrong");

  chk_ler_capture: assert property (
    push && rec_en && push_kind != LBRS_KIND_BRANCH
    |=> ler == $past(last_branch))
    else $error("last-exception pair not captured");

  chk_step_branch: assert property (
    ctl[`LBRS_CTL_STEP_BIT] && TRAP_FLAG_IN && !push |=> !STEP_TRAP_OUT)
    else $error("step trap without a branch");

  chk_buf_irq: assert property (
    BUF_IRQ_OUT |-> $past(ctl[`LBRS_CTL_IRQ_BIT]) && $past(BUF_FULL_IN))
    else $error("buffer interrupt without cause");

  // bounds, stall, store request, circular mode and register port checks

  chk_ptr_range: assert property (
    ptr <= PTR_MAX)
    else $error("pointer beyond last entry");

  chk_ready_stall: assert property (
    take && EVT_IN.with_branch && EVT_IN.kind != LBRS_KIND_BRANCH
    |=> !EVT_READY_OUT ##1 EVT_READY_OUT)
    else $error("paired event did not stall one cycle");

  chk_store_req: assert property (
    push && ctl[`LBRS_CTL_STORE_BIT] |=> STORE_VALID_OUT)
    else $error("store request missing");

  chk_ctl_mask: assert property (
    (ctl & ~(`LBRS_CTL_WMASK)) == 64'h0)
    else $error("control holds an unknown bit");

  chk_circ_mode: assert property (
    ctl[`LBRS_CTL_STORE_BIT] && !ctl[`LBRS_CTL_IRQ_BIT]
    |=> STORE_CIRCULAR_OUT)
    else $error("circular logging not flagged");

  chk_entry_ro: assert property (
    MSR_WR_IN && is_entry(MSR_ADDR_IN) |=> MSR_FAULT_OUT)
    else $error("write to entry not refused");

  chk_read_ack: assert property (
    MSR_RD_IN |=> MSR_ACK_OUT)
    else $error("read not answered next cycle");

endmodule // lbrs_stack

/* File: bench/lbrs_core_model.sv */
// model of the core's retirement logic offering record events
module lbrs_core_model
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   send_in,   // start one offer
  input  wire logic [3:0]             delay_in,  // idle cycles first
  input  wire lbrs_pkg::lbrs_evt_type evt_in,
  input  wire logic                   ready_in,
  output logic                        valid_out,
  output lbrs_pkg::lbrs_evt_type      evt_out,
  output logic                        busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import lbrs_pkg::*;

  logic         pending;  // offer waiting out its delay
  logic [3:0]   wait_cnt; // cycles left before valid
  lbrs_evt_type held;     // event being offered

  // offer held until taken; bus scrambled when idle so stale data is seen
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pending   <= 1'b0;
      wait_cnt  <= 4'h0;
      valid_out <= 1'b0;
      held      <= '0;
      evt_out   <= '0;
    end
    else if (send_in && !pending && !valid_out)
    begin
      pending  <= 1'b1;
      wait_cnt <= delay_in;
      held     <= evt_in;
      evt_out  <= ~evt_in;
    end
    else if (pending && wait_cnt == 4'h0)
    begin
      pending   <= 1'b0;
      valid_out <= 1'b1;
      evt_out   <= held;
    end
    else if (pending)
      wait_cnt <= wait_cnt - 4'h1;
    else if (valid_out && ready_in)
    begin
      valid_out <= 1'b0;
      evt_out   <= ~evt_out;
    end
  end

  assign busy_out = pending | valid_out;
endmodule // lbrs_core_model

/* File: bench/last_branch_record_stack_tb_top.sv */
// self-checking bench for the branch record stack
`include "lbrs_regs.svh"
module last_branch_record_stack_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lbrs_pkg::*;

  logic         clk = 0, rst_n = 0;  // clock and active-low reset
  logic         send = 0, trap = 0, retire = 0, dbg = 0, full = 0;
  logic         rd = 0, wr = 0;      // register strobes
  logic [31:0]  addr = '0;
  logic [63:0]  wdata = '0, rdata;
  logic [3:0]   dly = '0;            // partner delay
  lbrs_evt_type evt = '0, evt_w;
  lbrs_rec_type trec;
  logic [31:0]  feat;
  logic         valid, ready, busy, step, trc, sto, irq, circ, ack, fault;
  int error_cnt = 0, samples_checked = 0;
  int n_trc = 0, n_sto = 0, n_irq = 0, n_step = 0;
  int p = 0;                         // expected pointer

  always #50 clk = ~clk;

  // pulse counters, since pulses last one cycle only
  always @(posedge clk)
  begin
    n_trc  += (trc === 1'b1);
    n_sto  += (sto === 1'b1);
    n_irq  += (irq === 1'b1);
    n_step += (step === 1'b1);
  end

  lbrs_core_model u_core (.clk_in(clk), .rst_n_in(rst_n), .send_in(send),
    .delay_in(dly), .evt_in(evt), .ready_in(ready), .valid_out(valid),
    .evt_out(evt_w), .busy_out(busy));

  lbrs_stack #(.DEPTH(8)) u_dut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .EVT_VALID_IN(valid), .EVT_IN(evt_w), .EVT_READY_OUT(ready),
    .TRAP_FLAG_IN(trap), .INSN_RETIRE_IN(retire), .DBG_EXC_IN(dbg),
    .STEP_TRAP_OUT(step), .TRACE_VALID_OUT(trc), .STORE_VALID_OUT(sto),
    .TRACE_REC_OUT(trec), .BUF_FULL_IN(full), .BUF_IRQ_OUT(irq),
    .STORE_CIRCULAR_OUT(circ), .FEATURES_OUT(feat), .MSR_RD_IN(rd),
    .MSR_WR_IN(wr), .MSR_ADDR_IN(addr), .MSR_WDATA_IN(wdata),
    .MSR_RDATA_OUT(rdata), .MSR_ACK_OUT(ack), .MSR_FAULT_OUT(fault));

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one strobe, answer sampled after the next edge
  task automatic reg_op(input logic w, input logic [31:0] a,
                        input logic [63:0] wd, output logic [63:0] d,
                        output logic f);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= wd;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    chk("ack", 1, ack);
    d = rdata;
    f = fault;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [63:0] e,
                        input string nm);
    logic [63:0] d;
    logic        f;
    reg_op(1'b0, a, '0, d, f);
    chk(nm, e, d);
    chk("fault", 0, f);
  endtask

  task automatic ctl_wr(input logic [63:0] v);
    logic [63:0] d;
    logic        f;
    reg_op(1'b1, `LBRS_ADDR_CTL, v, d, f);
  endtask

  // hand one event to the partner and wait until it is taken
  task automatic push(input lbrs_kind_type k, input logic wb,
                      input lbrs_rec_type br, r, input logic [3:0] dl);
    @(posedge clk);
    evt <= '{k, wb, br, r};
    dly <= dl;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1;
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk("busy", 0, busy);
  endtask

  task automatic t_reset;
    rd_chk(`LBRS_ADDR_TOP, 0, "ptr");
    rd_chk(`LBRS_ADDR_CTL, 0, "ctl");
    chk("features", 32'h0020_0000, feat);
  endtask

  // nine branches, pointer advances and wraps
  task automatic t_wrap;
    lbrs_rec_type r;
    ctl_wr(64'h1);
    for (int i = 0; i < 9; i++)
    begin
      r.dest = 32'hd000_0000 + 32'(i);
      r.src = 32'h5000_0000 + 32'(i);
      push(LBRS_KIND_BRANCH, 1'b0, '0, r, 4'(i % 3));
      p = (p + 1) % 8;
      rd_chk(`LBRS_ADDR_TOP, 64'(p), "ptr");
      rd_chk(`LBRS_ADDR_ENTRY0 + 32'(p), r, "entry");
    end
  endtask

  // stack read-only, unmapped read refused, control mask
  task automatic t_ro;
    logic [63:0] d;
    logic        f;
    reg_op(1'b1, `LBRS_ADDR_TOP, 64'h5, d, f);
    chk("fault", 1, f);
    reg_op(1'b1, `LBRS_ADDR_ENTRY0, '1, d, f);
    chk("fault", 1, f);
    rd_chk(`LBRS_ADDR_TOP, 64'(p), "ptr");
    reg_op(1'b0, `LBRS_ADDR_ENTRY0 + 32'h8, '0, d, f);
    chk("fault", 1, f);
    chk("rdata", 0, d);
    ctl_wr('1);
    rd_chk(`LBRS_ADDR_CTL, 64'h1c3, "ctl");
  endtask

  // interrupt and exception after a branch push two records
  task automatic t_pair;
    lbrs_rec_type br, r;
    ctl_wr(64'h1);
    for (int j = 1; j < 3; j++)
    begin
      br = {32'hb100_0000 + 32'(j), 32'hb000_0000 + 32'(j)};
      r = {32'he100_0000 + 32'(j), 32'he000_0000 + 32'(j)};
      push(lbrs_kind_type'(2'(j)), 1'b1, br, r, 4'h2);
      chk("ready", 0, ready);
      rd_chk(`LBRS_ADDR_TOP, 64'((p + 2) % 8), "ptr");
      rd_chk(`LBRS_ADDR_ENTRY0 + 32'((p + 1) % 8), br, "first");
      rd_chk(`LBRS_ADDR_ENTRY0 + 32'((p + 2) % 8), r, "second");
      p = (p + 2) % 8;
      rd_chk(`LBRS_ADDR_LER_SRC, 64'(br.src), "ler_src");
      rd_chk(`LBRS_ADDR_LER_DST, 64'(br.dest), "ler_dst");
      chk("ready", 1, ready);
    end
  endtask

  // trace and store pulses follow their control bits
  task automatic t_trace;
    logic [63:0]  c[4] = '{64'h01, 64'h41, 64'h81, 64'hc1};
    lbrs_rec_type r;
    int           a, b;
    for (int j = 0; j < 4; j++)
    begin
      ctl_wr(c[j]);
      a = n_trc;
      b = n_sto;
      r = {32'h7700_0000 + 32'(j), 32'h6600_0000 + 32'(j)};
      push(LBRS_KIND_BRANCH, 1'b0, '0, r, 4'h0);
      p = (p + 1) % 8;
      cyc(3);
      chk("trace", c[j][6], 64'(n_trc - a));
      chk("store", c[j][7], 64'(n_sto - b));
      chk("trace_rec", r, trec);
    end
  endtask

  // full buffer interrupts only with bit 8, else circular logging
  task automatic t_buf;
    logic [63:0] c[2] = '{64'h181, 64'h081};
    int          a;
    for (int j = 0; j < 2; j++)
    begin
      ctl_wr(c[j]);
      cyc(2);
      chk("circular", !c[j][8], circ);
      a = n_irq;
      full <= 1'b1;
      cyc(3);
      chk("irq", c[j][8], 64'(n_irq - a));
      full <= 1'b0;
    end
  endtask

  // trap flag steps branches with bit 1, instructions without
  task automatic t_step;
    int a;
    ctl_wr(64'h3);
    @(posedge clk);
    trap <= 1'b1;
    a = n_step;
    @(posedge clk);
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
    cyc(3);
    chk("step", 0, 64'(n_step - a));
    push(LBRS_KIND_BRANCH, 1'b0, '0, 64'h1234, 4'h0);
    p = (p + 1) % 8;
    cyc(3);
    chk("step", 1, 64'(n_step - a));
    ctl_wr(64'h1);
    a = n_step;
    @(posedge clk);
    retire <= 1'b1;
    @(posedge clk);
    retire <= 1'b0;
    cyc(3);
    chk("step", 1, 64'(n_step - a));
    trap <= 1'b0;
  endtask

  // recording off freezes the stack; debug exception clears bit 0
  task automatic t_off;
    ctl_wr(64'h0);
    push(LBRS_KIND_BRANCH, 1'b0, '0, 64'h9999, 4'h1);
    rd_chk(`LBRS_ADDR_TOP, 64'(p), "ptr");
    ctl_wr(64'h1);
    @(posedge clk);
    dbg <= 1'b1;
    @(posedge clk);
    dbg <= 1'b0;
    rd_chk(`LBRS_ADDR_CTL, 0, "ctl");
  endtask

  // main sequence
  initial
  begin
    cyc(4);
    rst_n <= 1'b1;
    t_reset;
    t_wrap;
    t_ro;
    t_pair;
    t_trace;
    t_buf;
    t_step;
    t_off;
    results;
  end

  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #(5000 * 100);
    error_cnt++;
    results;
  end
endmodule // last_branch_record_stack_tb_top
